// File: include/rpr_pkg.sv
/*
  rpr_pkg: constants for the read-parameter register bank of a serial flash:
  command opcodes, field positions, reset values and default dummy counts.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rpr_pkg;

  // set-read-parameter opcodes
  localparam logic [7:0] RPR_OP_SET_NV = 8'h65;
  localparam logic [7:0] RPR_OP_SET_VOL_A = 8'hc0;
  localparam logic [7:0] RPR_OP_SET_VOL_B = 8'h63;

  // read_parameter_reg layout
  localparam int RPR_W = 8;
  localparam logic [7:0] RPR_RESET = 8'h00;
  localparam int RPR_PIN_FUNCTION_SELECT = 7;
  localparam int RPR_DUMMY_HI = 6;
  localparam int RPR_DUMMY_LO = 3;
  localparam int RPR_WRAP_ENABLE_BIT = 2;
  localparam int RPR_BURST_LEN_HIGH = 1;
  localparam int RPR_BURST_LEN_LOW = 0;

  // link framing: edges per command in each mode
  localparam logic [4:0] RPR_EDGES_SINGLE = 5'h10;
  localparam logic [4:0] RPR_EDGES_QUAD = 5'h04;

  // default dummy counts when the dummy field is zero
  localparam logic [3:0] RPR_DUMMY_DEF_SINGLE = 4'h8;
  localparam logic [3:0] RPR_DUMMY_DEF_QUAD = 4'h6;
  localparam logic [3:0] RPR_DUMMY_DEF_DUAL_IO = 4'h4;

  localparam int RPR_ADDR_W = 23;

  // read command families that share a default dummy count
  typedef enum logic [1:0] {
    RPR_KIND_SINGLE_DUAL_OUT = 2'b00,
    RPR_KIND_QUAD = 2'b01,
    RPR_KIND_DUAL_IO = 2'b10
  } rpr_kind_type;

  typedef enum logic [1:0] {
    RPR_ST_LOAD = 2'b00,
    RPR_ST_RUN = 2'b01
  } rpr_state_type;

endpackage

// File: core/rpr_bank.sv
/*
  rpr_bank: read-parameter register pair (non-volatile and volatile copy)
  written over the serial link by the set-read-parameter commands, with the
  decoded pin function, dummy count and a wrapping read address counter.
  Assumes: sck is the link clock and only toggles while cs_n is low; the host
  leaves at least 8 clk_sys cycles after a frame's last edge before the
  next frame's capture point; configuration inputs are on clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module rpr_bank
  import rpr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] link_data_in,
  // device configuration, clk_sys domain
  input wire logic quad_enable,
  input wire logic quad_command_mode,
  input wire logic has_dedicated_reset,
  input wire logic dedicated_reset_disable,
  input wire logic reload_req,
  // read sequencing, clk_sys domain
  input wire logic [1:0] rd_kind,
  input wire logic addr_load,
  input wire logic [RPR_ADDR_W-1:0] addr_start,
  input wire logic addr_step,
  // results
  output logic params_ready,
  output logic [RPR_W-1:0] read_params,
  output logic [RPR_W-1:0] read_params_nv,
  output logic pin_is_hold,
  output logic pin_is_reset,
  output logic pin_is_data_line_three,
  output logic [3:0] dummy_cycles,
  output logic wrap_active,
  output logic [6:0] burst_bytes,
  output logic [RPR_ADDR_W-1:0] rd_addr
);

  // link domain: frame capture
  logic [4:0] edge_cnt_r;
  logic [15:0] single_shift_r;
  logic [11:0] quad_shift_r;
  logic [15:0] single_cmd_r;
  logic [15:0] quad_cmd_r;
  logic single_tgl_r;
  logic quad_tgl_r;

  // clk_sys domain
  logic [2:0] single_sync_r;
  logic [2:0] quad_sync_r;
  logic single_seen_r;
  logic quad_seen_r;
  rpr_state_type state_r;
  logic [RPR_W-1:0] nv_r;
  logic [RPR_W-1:0] vol_r;
  logic ready_r;
  logic hold_r;
  logic reset_fn_r;
  logic dl3_r;
  logic [3:0] dummy_r;
  logic [3:0] dummy_nxt;
  logic wrap_r;
  logic [6:0] burst_r;
  logic [RPR_ADDR_W-1:0] addr_r;

  logic single_evt;
  logic quad_evt;
  logic cmd_valid;
  logic [7:0] cmd_op;
  logic [7:0] cmd_data;
  logic [RPR_W-1:0] vol_nxt;

  function automatic logic [6:0] burst_size(input logic [1:0] len);
    burst_size = 7'h08 << len;
  endfunction

  // both volatile opcodes must decode alike wherever a write is recognised
  function automatic logic op_is_vol_write(input logic [7:0] op);
    op_is_vol_write = (op == RPR_OP_SET_VOL_A) || (op == RPR_OP_SET_VOL_B);
  endfunction

  function automatic logic [RPR_ADDR_W-1:0] next_addr(
    input logic [RPR_ADDR_W-1:0] addr,
    input logic wrap,
    input logic [1:0] len
  );
    logic [RPR_ADDR_W-1:0] mask;
    logic [RPR_ADDR_W-1:0] inc;
    mask = RPR_ADDR_W'(burst_size(len)) - RPR_ADDR_W'(1);
    inc = addr + RPR_ADDR_W'(1);
    if (wrap) begin
      next_addr = (addr & ~mask) | (inc & mask);
    end else begin
      next_addr = inc;
    end
  endfunction

  // the frame counter clears on cs_n high because sck may stop after the
  // last edge; nothing else is left to finish in this domain
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      edge_cnt_r <= 5'h00;
    end else if (edge_cnt_r != RPR_EDGES_SINGLE) begin
      edge_cnt_r <= edge_cnt_r + 5'h01;
    end
  end

  // no reset: a full frame always refills both shifters before its capture edge
  always_ff @(posedge sck) begin
    single_shift_r <= {single_shift_r[14:0], link_data_in[0]};
    quad_shift_r <= {quad_shift_r[7:0], link_data_in};
  end

  // both framings are captured; clk_sys picks the one matching its mode,
  // so the mode never has to cross into a clock that may be stopped
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      single_tgl_r <= 1'b0;
      quad_tgl_r <= 1'b0;
    end else if (!cs_n) begin
      if (edge_cnt_r == RPR_EDGES_SINGLE - 5'h01) begin
        single_tgl_r <= ~single_tgl_r;
      end
      if (edge_cnt_r == RPR_EDGES_QUAD - 5'h01) begin
        quad_tgl_r <= ~quad_tgl_r;
      end
    end
  end

  always_ff @(posedge sck) begin
    if (!cs_n && edge_cnt_r == RPR_EDGES_SINGLE - 5'h01) begin
      single_cmd_r <= {single_shift_r[14:0], link_data_in[0]};
    end
    if (!cs_n && edge_cnt_r == RPR_EDGES_QUAD - 5'h01) begin
      quad_cmd_r <= {quad_shift_r, link_data_in};
    end
  end

  // toggle crossing: an event counts once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      single_sync_r <= 3'h0;
    end else begin
      single_sync_r <= {single_sync_r[1:0], single_tgl_r};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      quad_sync_r <= 3'h0;
    end else begin
      quad_sync_r <= {quad_sync_r[1:0], quad_tgl_r};
    end
  end

  assign single_evt = (single_sync_r[1] == single_sync_r[2]) &&
                      (single_sync_r[2] != single_seen_r);
  assign quad_evt = (quad_sync_r[1] == quad_sync_r[2]) &&
                    (quad_sync_r[2] != quad_seen_r);

  // events are held pending while the power-up load runs, so a frame that
  // lands during the load is applied after it instead of being lost
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      single_seen_r <= 1'b0;
    end else if (state_r == RPR_ST_RUN && single_evt) begin
      single_seen_r <= single_sync_r[2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      quad_seen_r <= 1'b0;
    end else if (state_r == RPR_ST_RUN && quad_evt) begin
      quad_seen_r <= quad_sync_r[2];
    end
  end

  always_comb begin
    if (quad_command_mode) begin
      cmd_valid = quad_evt && (state_r == RPR_ST_RUN);
      // quad framing: opcode nibbles on the first two edges, data on the last two
      cmd_op = quad_cmd_r[15:8];
      cmd_data = quad_cmd_r[7:0];
    end else begin
      cmd_valid = single_evt && (state_r == RPR_ST_RUN);
      cmd_op = single_cmd_r[15:8];
      cmd_data = single_cmd_r[7:0];
    end
  end

  // reload_req stands in for a power cycle: the stored copy is kept
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= RPR_ST_LOAD;
    end else begin
      case (state_r)
        RPR_ST_LOAD: state_r <= RPR_ST_RUN;
        RPR_ST_RUN: if (reload_req) state_r <= RPR_ST_LOAD;
        default: state_r <= RPR_ST_LOAD;
      endcase
    end
  end

  // non-volatile copy: survives reload_req, cleared only by rst_n
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nv_r <= RPR_RESET;
    end else if (cmd_valid && cmd_op == RPR_OP_SET_NV) begin
      nv_r <= cmd_data;
    end
  end

  always_comb begin
    vol_nxt = vol_r;
    if (state_r == RPR_ST_LOAD) begin
      vol_nxt = nv_r;
    end else if (cmd_valid && op_is_vol_write(cmd_op)) begin
      vol_nxt = cmd_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vol_r <= RPR_RESET;
    end else begin
      vol_r <= vol_nxt;
    end
  end

  // ready trails the load by one edge, so the derived outputs are already valid
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= (state_r == RPR_ST_RUN);
    end
  end

  // shared pin function follows the governing volatile copy
  // priority: quad use of the pin, then an enabled separate reset pin
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hold_r <= 1'b1;
      reset_fn_r <= 1'b0;
      dl3_r <= 1'b0;
    end else if (quad_enable || quad_command_mode) begin
      hold_r <= 1'b0;
      reset_fn_r <= 1'b0;
      dl3_r <= 1'b1;
    end else if (has_dedicated_reset && !dedicated_reset_disable) begin
      hold_r <= 1'b1;
      reset_fn_r <= 1'b0;
      dl3_r <= 1'b0;
    end else begin
      hold_r <= ~vol_r[RPR_PIN_FUNCTION_SELECT];
      reset_fn_r <= vol_r[RPR_PIN_FUNCTION_SELECT];
      dl3_r <= 1'b0;
    end
  end

  // a zero field falls back to the default of the read family in use
  always_comb begin
    if (vol_r[RPR_DUMMY_HI:RPR_DUMMY_LO] != 4'h0) begin
      dummy_nxt = vol_r[RPR_DUMMY_HI:RPR_DUMMY_LO];
    end else begin
      case (rd_kind)
        RPR_KIND_QUAD: dummy_nxt = RPR_DUMMY_DEF_QUAD;
        RPR_KIND_DUAL_IO: dummy_nxt = RPR_DUMMY_DEF_DUAL_IO;
        default: dummy_nxt = RPR_DUMMY_DEF_SINGLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dummy_r <= RPR_DUMMY_DEF_SINGLE;
    end else begin
      dummy_r <= dummy_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrap_r <= 1'b0;
    end else begin
      wrap_r <= vol_r[RPR_WRAP_ENABLE_BIT];
    end
  end

  // burst size is a status copy; the address walk reads the live field
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      burst_r <= burst_size(2'b00);
    end else begin
      burst_r <= burst_size(vol_r[RPR_BURST_LEN_HIGH:RPR_BURST_LEN_LOW]);
    end
  end

  // read address walk; the window size is taken from the live volatile copy
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      addr_r <= '0;
    end else if (addr_load) begin
      addr_r <= addr_start;
    end else if (addr_step) begin
      addr_r <= next_addr(addr_r, vol_r[RPR_WRAP_ENABLE_BIT],
                          vol_r[RPR_BURST_LEN_HIGH:RPR_BURST_LEN_LOW]);
    end
  end

  assign params_ready = ready_r;
  assign read_params = vol_r;
  assign read_params_nv = nv_r;
  assign pin_is_hold = hold_r;
  assign pin_is_reset = reset_fn_r;
  assign pin_is_data_line_three = dl3_r;
  assign dummy_cycles = dummy_r;
  assign wrap_active = wrap_r;
  assign burst_bytes = burst_r;
  assign rd_addr = addr_r;

endmodule // rpr_bank
`default_nettype wire

// File: verification/rpr_host_model.sv
/*
  rpr_host_model: host side of the link, sends set-read-parameter frames.
  Assumes the caller spaces frames; sck idles low outside frames.
*/
`timescale 1ns/100ps
`default_nettype none
module rpr_host_model (
  output logic sck,
  output logic cs_n,
  output logic [3:0] link_data_in
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    link_data_in = 4'h0;
    // one clean rising edge of cs_n clears the frame counter before any frame
    #1 cs_n = 1'b1;
  end
  // 64 ns link period keeps any dummy setting legal
  task automatic frame(input logic [15:0] w, input int n, input bit q);
    for (int i = 0; i < n; i++) begin
      link_data_in = q ? w[15-4*i -: 4] : {3'b000, w[15-i]};
      cs_n = 1'b0;
      #16 sck = 1'b1;
      #32 sck = 1'b0;
      #16;
    end
    cs_n = 1'b1;
    // released lines must not keep showing the last bit
    link_data_in = ~link_data_in;
  endtask
endmodule // rpr_host_model
`default_nettype wire

// File: verification/rpr_bank_chk.sv
/*
  rpr_bank_chk: assertions on rpr_bank ports, clk_sys domain.
  Assumes rpr_pkg is compiled first; bound below.
*/
`timescale 1ns/100ps
`default_nettype none
module rpr_bank_chk
  import rpr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic quad_enable,
  input wire logic quad_command_mode,
  input wire logic has_dedicated_reset,
  input wire logic dedicated_reset_disable,
  input wire logic [1:0] rd_kind,
  input wire logic addr_load,
  input wire logic [RPR_ADDR_W-1:0] addr_start,
  input wire logic addr_step,
  input wire logic params_ready,
  input wire logic [RPR_W-1:0] read_params,
  input wire logic [RPR_W-1:0] read_params_nv,
  input wire logic pin_is_hold,
  input wire logic pin_is_reset,
  input wire logic pin_is_data_line_three,
  input wire logic [3:0] dummy_cycles,
  input wire logic wrap_active,
  input wire logic [6:0] burst_bytes,
  input wire logic [RPR_ADDR_W-1:0] rd_addr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic sel_q = quad_enable | quad_command_mode;
  wire logic sel_f = !sel_q && has_dedicated_reset && !dedicated_reset_disable;
  wire logic sel_b = !sel_q && !sel_f;
  wire logic [3:0] dfld = read_params[6:3];
  wire logic [3:0] ddef = rd_kind == RPR_KIND_QUAD ? RPR_DUMMY_DEF_QUAD :
    rd_kind == RPR_KIND_DUAL_IO ? RPR_DUMMY_DEF_DUAL_IO : RPR_DUMMY_DEF_SINGLE;
  wire logic [22:0] msk = {16'h0000, (7'h08 << read_params[1:0]) - 7'h01};
  wire logic [22:0] inc = rd_addr + 23'h000001;
  wire logic [22:0] stp = read_params[2] ? (rd_addr & ~msk) | (inc & msk) : inc;
  a_vol_loaded: assert property ($rose(params_ready) |-> read_params == read_params_nv)
    else $error("volatile copy differs from stored copy at load");
  a_quad_pin: assert property (
    params_ready && sel_q && $past(sel_q)
    |-> {pin_is_hold, pin_is_reset, pin_is_data_line_three} == 3'b001)
    else $error("shared pin not data line three in quad");
  a_hold_forced: assert property (params_ready && sel_f && $past(sel_f) |-> pin_is_hold)
    else $error("hold not forced by dedicated reset pin");
  a_pin_select: assert property (
    params_ready && sel_b && $past(sel_b) && $stable(read_params)
    |-> {pin_is_hold, pin_is_reset} == {!read_params[7], read_params[7]})
    else $error("shared pin function does not follow bit 7");
  a_burst_map: assert property (
    params_ready && $stable(read_params)
    |-> {wrap_active, burst_bytes} == {read_params[2], 7'h08 << read_params[1:0]})
    else $error("burst size or wrap flag wrong");
  a_dummy_map: assert property (
    params_ready && $stable(read_params) && $stable(rd_kind)
    |-> dummy_cycles == (dfld != 4'h0 ? dfld : ddef))
    else $error("dummy count wrong");
  a_addr_load: assert property (addr_load |=> rd_addr == $past(addr_start))
    else $error("address not loaded");
  a_addr_step: assert property (addr_step && !addr_load |=> rd_addr == $past(stp))
    else $error("address step wrong");
  c_load: cover property ($rose(params_ready));
  c_wrap_step: cover property (addr_step && read_params[2]);
  c_reset_pin: cover property (pin_is_reset);
endmodule // rpr_bank_chk
bind rpr_bank rpr_bank_chk i_chk (.clk_sys, .rst_n, .quad_enable, .quad_command_mode,
  .has_dedicated_reset, .dedicated_reset_disable, .rd_kind, .addr_load, .addr_start,
  .addr_step, .params_ready, .read_params, .read_params_nv, .pin_is_hold, .pin_is_reset,
  .pin_is_data_line_three, .dummy_cycles, .wrap_active, .burst_bytes, .rd_addr);
`default_nettype wire

// File: verification/tb_top.sv
/*
  tb_top: directed scenarios for rpr_bank driven through the host model.
  Assumes rpr_pkg, rpr_bank, the model and the checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import rpr_pkg::*;
  logic rst_n = 1'b1;
  logic clk_sys, quad_enable, quad_command_mode, has_dedicated_reset;
  logic dedicated_reset_disable, reload_req, addr_load, addr_step;
  logic [1:0] rd_kind;
  logic [22:0] addr_start;
  wire logic sck, cs_n;
  wire logic [3:0] link_data_in;
  logic params_ready, pin_is_hold, pin_is_reset, pin_is_data_line_three, wrap_active;
  logic [7:0] read_params, read_params_nv;
  logic [3:0] dummy_cycles;
  logic [6:0] burst_bytes;
  logic [22:0] rd_addr;
  int n_mismatch = 0;
  int compares = 0;
  rpr_host_model i_host (.sck, .cs_n, .link_data_in);
  rpr_bank i_dut (.clk_sys, .rst_n, .sck, .cs_n, .link_data_in, .quad_enable,
    .quad_command_mode, .has_dedicated_reset, .dedicated_reset_disable, .reload_req,
    .rd_kind, .addr_load, .addr_start, .addr_step, .params_ready, .read_params,
    .read_params_nv, .pin_is_hold, .pin_is_reset, .pin_is_data_line_three,
    .dummy_cycles, .wrap_active, .burst_bytes, .rd_addr);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic cmp(input logic [22:0] got, input logic [22:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // ten cycles cover sync, register and derived stages
  task automatic frm(input logic [7:0] op, input logic [7:0] d, input int n = 16, input bit q = 0);
    i_host.frame({op, d}, n, q);
    tick(10);
  endtask
  task automatic s_regs;
    frm(RPR_OP_SET_VOL_A, 8'h5a);
    cmp({read_params_nv, read_params}, 16'h005a);
    frm(RPR_OP_SET_VOL_B, 8'ha5);
    cmp({read_params_nv, read_params}, 16'h00a5);
    frm(RPR_OP_SET_NV, 8'h3c);
    cmp({read_params_nv, read_params}, 16'h3ca5);
    frm(8'h66, 8'h11);
    frm(RPR_OP_SET_VOL_A, 8'h77, 12);
    cmp({read_params_nv, read_params}, 16'h3ca5);
    @(posedge clk_sys) reload_req <= 1'b1;
    @(posedge clk_sys) reload_req <= 1'b0;
    tick(6);
    cmp(read_params, 8'h3c);
    cmp(params_ready, 1'b1);
  endtask
  task automatic s_pin;
    logic [3:0] cfg [5] = '{4'h0, 4'h2, 4'h1, 4'h8, 4'hc};
    logic [2:0] ex [5] = '{3'b010, 3'b001, 3'b001, 3'b100, 3'b010};
    frm(RPR_OP_SET_VOL_A, 8'h80);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      {has_dedicated_reset, dedicated_reset_disable, quad_enable, quad_command_mode} <= cfg[i];
      tick(3);
      cmp({pin_is_hold, pin_is_reset, pin_is_data_line_three}, ex[i]);
    end
    @(posedge clk_sys);
    {has_dedicated_reset, dedicated_reset_disable, quad_command_mode} <= 3'b001;
    frm(RPR_OP_SET_VOL_A, 8'h81);
    cmp(read_params, 8'h80);
    frm(RPR_OP_SET_VOL_B, 8'h18, 4, 1'b1);
    cmp(read_params, 8'h18);
    @(posedge clk_sys) quad_command_mode <= 1'b0;
  endtask
  task automatic s_fields;
    logic [3:0] dflt [3] = '{RPR_DUMMY_DEF_SINGLE, RPR_DUMMY_DEF_QUAD, RPR_DUMMY_DEF_DUAL_IO};
    for (int i = 0; i < 4; i++) begin
      frm(RPR_OP_SET_VOL_A, {1'b0, 4'(i * 5), 1'b1, 2'(i)});
      for (int k = 0; k < 3; k++) begin
        @(posedge clk_sys) rd_kind <= 2'(k);
        tick(3);
        cmp(dummy_cycles, i != 0 ? 4'(i * 5) : dflt[k]);
      end
      cmp({wrap_active, burst_bytes}, {1'b1, 7'h08 << i});
    end
  endtask
  task automatic s_addr;
    logic [7:0] rp [3] = '{8'h04, 8'h00, 8'h07};
    logic [22:0] st [3] = '{23'h000007, 23'h000007, 23'h40007f};
    logic [22:0] ex [3] = '{23'h000000, 23'h000008, 23'h400040};
    for (int i = 0; i < 3; i++) begin
      frm(RPR_OP_SET_VOL_A, rp[i]);
      @(posedge clk_sys);
      addr_load <= 1'b1;
      addr_start <= st[i];
      @(posedge clk_sys);
      addr_load <= 1'b0;
      addr_step <= 1'b1;
      @(posedge clk_sys);
      addr_step <= 1'b0;
      tick(1);
      cmp(rd_addr, ex[i]);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    {quad_enable, quad_command_mode, has_dedicated_reset, dedicated_reset_disable,
      reload_req, addr_load, addr_step, rd_kind, addr_start} = '0;
    // reset falls on a clock edge, after every process is waiting on it
    @(posedge clk_sys) rst_n <= 1'b0;
    tick(20);
    @(posedge clk_sys) rst_n <= 1'b1;
    tick(4);
    cmp({read_params_nv, read_params}, {RPR_RESET, RPR_RESET});
    cmp({params_ready, pin_is_hold}, 2'b11);
    cmp({dummy_cycles, burst_bytes}, {RPR_DUMMY_DEF_SINGLE, 7'h08});
    s_regs;
    s_pin;
    s_fields;
    s_addr;
    close_out;
  end
  // hang guard well past the roughly 16 us of traffic
  initial begin
    #150000;
    n_mismatch++;
    close_out;
  end
endmodule // tb_top
`default_nettype wire
